// ==== rtl/pseqc_pkg.sv ====
// Package: constants and types of the pattern sequence controller
package pseqc_pkg;

   // ---------------------------------------------------------------
   // Sizes
   // ---------------------------------------------------------------
   localparam int unsigned MAX_ENTRIES   = 512;   // Sequence table depth
   localparam int unsigned REUSED_IMAGES = 112;   // Entries that must reuse images
   localparam int unsigned DISTINCT_IMGS = MAX_ENTRIES - REUSED_IMAGES;
   localparam int unsigned IDX_W         = 9;     // Entry index width
   localparam int unsigned IMG_W         = 9;     // Image index width
   localparam int unsigned TIME_W        = 24;    // Microsecond field width
   localparam int unsigned DEPTH_W       = 4;     // Bit depth field width

   // ---------------------------------------------------------------
   // Timing
   // ---------------------------------------------------------------
   localparam int unsigned CLK_MHZ    = 50;       // mclk rate in MHz
   localparam int unsigned US_CYCLES  = CLK_MHZ;  // Cycles per microsecond
   localparam int unsigned US_CNT_W   = 6;
   localparam logic [US_CNT_W-1:0] US_LAST = US_CNT_W'(US_CYCLES - 1);

   // ---------------------------------------------------------------
   // Bit depth limits
   // ---------------------------------------------------------------
   localparam logic [DEPTH_W-1:0] DEPTH_MIN = 4'h1;
   localparam logic [DEPTH_W-1:0] DEPTH_MAX = 4'h8;

   // ---------------------------------------------------------------
   // Enumerations
   // ---------------------------------------------------------------
   typedef enum logic [1:0] {
      PSEQC_SRC_FLASH  = 2'h0,  // Images from flash in internal memory
      PSEQC_SRC_VIDEO  = 2'h1,  // Images streamed from video input
      PSEQC_SRC_UPLOAD = 2'h2   // Images uploaded by host at run time
   } pseqc_src_type;

   typedef enum logic [1:0] {
      PSEQC_LINK_USB = 2'h0,
      PSEQC_LINK_I2C = 2'h1
   } pseqc_link_type;

   typedef enum logic [1:0] {
      PSEQC_COL_NONE  = 2'h0,
      PSEQC_COL_RED   = 2'h1,
      PSEQC_COL_GREEN = 2'h2,
      PSEQC_COL_BLUE  = 2'h3
   } pseqc_color_type;

   // Gray codes along idle -> expose -> dark -> paused
   typedef enum logic [1:0] {
      PSEQC_ST_IDLE   = 2'b00,
      PSEQC_ST_EXPOSE = 2'b01,
      PSEQC_ST_DARK   = 2'b11,
      PSEQC_ST_PAUSED = 2'b10
   } pseqc_state_type;

   // ---------------------------------------------------------------
   // Carriers
   // ---------------------------------------------------------------
   typedef struct packed {
      logic [DEPTH_W-1:0] depth;      // Bit depth
      logic [TIME_W-1:0]  expose_us;  // Exposure in microseconds
      logic [TIME_W-1:0]  dark_us;    // Dark time in microseconds
      pseqc_color_type    color;      // Colour selection
      logic [IMG_W-1:0]   image;      // Image index
   } pseqc_entry_type;

   typedef struct packed {
      logic [IDX_W-1:0]   index;      // Entry currently shown
      logic [DEPTH_W-1:0] depth;
      pseqc_color_type    color;
      logic [IMG_W-1:0]   image;
      logic               lit;        // Exposure active
      logic               curtain;    // Solid curtain shown
   } pseqc_show_type;

endpackage : pseqc_pkg

// ==== rtl/pseqc_ctrl.sv ====
// Pattern sequence controller: table upload, validation and playback
`timescale 1ns/1ps
`default_nettype none
module pseqc_ctrl
   import pseqc_pkg::*;
#(
   parameter int unsigned ENTRIES = MAX_ENTRIES
) (
   input  wire logic            mclk,
   input  wire logic            rst_n,
   input  wire pseqc_src_type   src_mode,
   input  wire logic            repeat_mode,
   input  wire logic            wr_en,
   input  wire pseqc_link_type  wr_link,
   input  wire logic [IDX_W-1:0] wr_index,
   input  wire pseqc_entry_type wr_entry,
   input  wire logic            wr_done,
   input  wire logic [IDX_W-1:0] wr_count,
   input  wire logic            cmd_start,
   input  wire logic            cmd_pause,
   input  wire logic            cmd_stop,
   input  wire logic            vid_vsync,
   input  wire logic            vid_locked,
   output pseqc_show_type       show,
   output logic                 seq_running,
   output logic                 seq_error,
   output logic                 seq_valid
);

   // ---------------------------------------------------------------
   // Storage
   // ---------------------------------------------------------------
   pseqc_entry_type  table_q [ENTRIES];   // Sequence definition table
   logic [IDX_W-1:0] last_q;              // Index of last entry
   logic [IDX_W-1:0] cur_q;               // Entry in play
   logic [TIME_W-1:0] us_left_q;          // Microseconds left in phase
   logic [US_CNT_W-1:0] tick_q;           // Cycle prescaler
   pseqc_state_type  state_q;
   pseqc_entry_type  cur_e;               // Entry being shown
   logic             us_tick;             // One microsecond passed
   logic             phase_end;           // Current phase finished
   logic             last_entry;
   logic             bad_entry;           // Upload word fails checks
   logic [2:0]       vs_q;                // Vsync synchroniser
   logic [2:0]       lk_q;                // Lock synchroniser
   logic             vs_lvl_q;            // Filtered vsync level
   logic             lk_lvl_q;            // Filtered lock level
   logic             vs_rise;

   assign cur_e      = table_q[cur_q];
   assign last_entry = (cur_q == last_q);

   // ---------------------------------------------------------------
   // Pin synchronisers, change counts when stages 2 and 3 agree
   // ---------------------------------------------------------------
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         vs_q     <= 3'h0;
         lk_q     <= 3'h0;
         vs_lvl_q <= 1'b0;
         lk_lvl_q <= 1'b0;
      end else begin
         vs_q <= {vs_q[1:0], vid_vsync};
         lk_q <= {lk_q[1:0], vid_locked};
         if (vs_q[1] == vs_q[2]) begin
            vs_lvl_q <= vs_q[2];
         end
         if (lk_q[1] == lk_q[2]) begin
            lk_lvl_q <= lk_q[2];
         end
      end
   end
   assign vs_rise = (vs_q[1] == vs_q[2]) && vs_q[2] && !vs_lvl_q;

   // ---------------------------------------------------------------
   // Upload checks: depth range, image within distinct set
   // ---------------------------------------------------------------
   always_comb begin
      bad_entry = (wr_entry.depth < DEPTH_MIN) || (wr_entry.depth > DEPTH_MAX)
                  || (wr_entry.expose_us == '0)
                  || (32'(wr_entry.image) >= DISTINCT_IMGS)
                  || (32'(wr_index) >= ENTRIES);
      // Any link code other than USB or I2C fails the check, whatever the source
      if (wr_link != PSEQC_LINK_USB && wr_link != PSEQC_LINK_I2C) begin
         bad_entry = 1'b1;
      end
   end

   // ---------------------------------------------------------------
   // Table write, either link writes the same port
   // ---------------------------------------------------------------
   always_ff @(posedge mclk) begin
      if (wr_en && state_q == PSEQC_ST_IDLE && 32'(wr_index) < ENTRIES) begin
         table_q[wr_index] <= wr_entry;
      end
   end

   // ---------------------------------------------------------------
   // Validity and error status; error is sticky until reset
   // ---------------------------------------------------------------
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         seq_error <= 1'b0;
         seq_valid <= 1'b0;
         last_q    <= '0;
      end else begin
         if (wr_en && state_q == PSEQC_ST_IDLE) begin
            seq_valid <= 1'b0;
            if (bad_entry) begin
               seq_error <= 1'b1;
            end
         end else if (wr_done) begin
            last_q    <= wr_count;
            // Sequence usable only if no word failed; error set wins
            seq_valid <= !seq_error && (32'(wr_count) < ENTRIES);
            if (32'(wr_count) >= ENTRIES) begin
               seq_error <= 1'b1;
            end
         end
         if (cmd_start && !seq_valid) begin
            seq_error <= 1'b1;
         end
      end
   end

   // ---------------------------------------------------------------
   // Microsecond prescaler, running through expose and dark, cleared in idle and paused
   // ---------------------------------------------------------------
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         tick_q <= '0;
      end else if (state_q == PSEQC_ST_EXPOSE || state_q == PSEQC_ST_DARK) begin
         tick_q <= us_tick ? '0 : tick_q + 1'b1;
      end else begin
         // Idle or paused: next phase must get a full first microsecond
         tick_q <= '0;
      end
   end
   assign us_tick   = (tick_q == US_LAST);
   // Video mode ends a pattern on vsync, not on its own timer
   assign phase_end = (src_mode == PSEQC_SRC_VIDEO) ? vs_rise
                      : (us_tick && us_left_q <= TIME_W'(1));

   // ---------------------------------------------------------------
   // Playback state machine; stop has priority, then pause, except in idle where only start is decoded
   // ---------------------------------------------------------------
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         state_q   <= PSEQC_ST_IDLE;
         cur_q     <= '0;
         us_left_q <= '0;
      end else begin
         case (state_q)
            PSEQC_ST_IDLE: begin
               if (cmd_start && seq_valid) begin
                  cur_q     <= '0;
                  us_left_q <= table_q[0].expose_us;
                  state_q   <= PSEQC_ST_EXPOSE;
               end
            end
            PSEQC_ST_EXPOSE: begin
               if (cmd_stop) begin
                  state_q <= PSEQC_ST_IDLE;
               end else if (cmd_pause) begin
                  state_q <= PSEQC_ST_PAUSED;
               end else if (us_tick) begin
                  us_left_q <= us_left_q - 1'b1;
                  if (phase_end) begin
                     // Dark interval follows this pattern's exposure
                     us_left_q <= cur_e.dark_us;
                     state_q   <= PSEQC_ST_DARK;
                  end
               end else if (phase_end) begin
                  us_left_q <= cur_e.dark_us;
                  state_q   <= PSEQC_ST_DARK;
               end
            end
            PSEQC_ST_DARK: begin
               if (cmd_stop) begin
                  state_q <= PSEQC_ST_IDLE;
               end else if (cmd_pause) begin
                  state_q <= PSEQC_ST_PAUSED;
               end else if (us_left_q == '0 || (us_tick && us_left_q == TIME_W'(1))
                            || src_mode == PSEQC_SRC_VIDEO) begin
                  if (last_entry && !repeat_mode) begin
                     state_q <= PSEQC_ST_IDLE;
                  end else begin
                     cur_q     <= last_entry ? '0 : cur_q + 1'b1;
                     us_left_q <= table_q[last_entry ? '0 : cur_q + 1'b1].expose_us;
                     state_q   <= PSEQC_ST_EXPOSE;
                  end
               end else if (us_tick) begin
                  us_left_q <= us_left_q - 1'b1;
               end
            end
            PSEQC_ST_PAUSED: begin
               if (cmd_stop) begin
                  state_q <= PSEQC_ST_IDLE;
               end else if (cmd_start) begin
                  // Resume the same pattern, its exposure rerun in full
                  us_left_q <= cur_e.expose_us;
                  state_q   <= PSEQC_ST_EXPOSE;
               end
            end
            default: begin
               state_q <= PSEQC_ST_IDLE;
            end
         endcase
      end
   end

   // ---------------------------------------------------------------
   // Display outputs, registered
   // ---------------------------------------------------------------
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         show        <= '0;
         seq_running <= 1'b0;
      end else begin
         show.index   <= cur_q;
         show.depth   <= cur_e.depth;
         show.color   <= cur_e.color;
         show.image   <= cur_e.image;
         show.lit     <= (state_q == PSEQC_ST_EXPOSE);
         // Losing lock in video mode falls back to a solid curtain
         show.curtain <= (src_mode == PSEQC_SRC_VIDEO) && !lk_lvl_q;
         seq_running  <= (state_q == PSEQC_ST_EXPOSE) || (state_q == PSEQC_ST_DARK);
      end
   end

endmodule : pseqc_ctrl
`default_nettype wire

// ==== sim/pseqc_monitor.sv ====
// Checker: port-level properties of the pattern sequence controller
`timescale 1ns/1ps
`default_nettype none
module pseqc_monitor
   import pseqc_pkg::*;
#(
   parameter int unsigned ENTRIES = MAX_ENTRIES
) (
   input wire logic           mclk,
   input wire logic           rst_n,
   input wire pseqc_src_type  src_mode,
   input wire logic           cmd_start,
   input wire logic           cmd_pause,
   input wire logic           cmd_stop,
   input wire logic           vid_locked,
   input wire pseqc_show_type show,
   input wire logic           seq_running,
   input wire logic           seq_error,
   input wire logic           seq_valid
);
   // ---------------------------------------------------------------
   // One clock domain, so one default clock and reset
   // ---------------------------------------------------------------
   default clocking cb @(posedge mclk); endclocking
   default disable iff (!rst_n);

   lit_run_a: assert property (show.lit |-> seq_running)
      else $error("lit while sequencer not running");
   depth_ok_a: assert property (show.lit |-> show.depth inside {[DEPTH_MIN:DEPTH_MAX]})
      else $error("bit depth out of range while lit");
   index_ok_a: assert property (show.index < ENTRIES)
      else $error("entry index beyond table");
   run_start_a: assert property (cmd_start && seq_valid && !seq_running && !cmd_pause
      && !cmd_stop |-> ##2 seq_running)
      else $error("valid start did not run");
   stop_halt_a: assert property (cmd_stop |-> ##[1:3] !seq_running)
      else $error("stop did not halt");
   pause_halt_a: assert property (cmd_pause |-> ##[1:3] !seq_running)
      else $error("pause did not halt");
   refuse_flag_a: assert property (cmd_start && !seq_valid |-> ##[1:3] seq_error)
      else $error("refused start left no error");
   refuse_run_a: assert property (cmd_start && !seq_valid && !seq_running
      |-> ##2 !seq_running)
      else $error("invalid sequence started");
   error_hold_a: assert property (seq_error |=> seq_error)
      else $error("error flag cleared");
   // Sync chain plus output register need a few cycles
   curtain_on_a: assert property ((src_mode == PSEQC_SRC_VIDEO && !vid_locked)[*6]
      |-> show.curtain)
      else $error("no curtain on lost lock");
endmodule : pseqc_monitor

bind pseqc_ctrl pseqc_monitor #(.ENTRIES(ENTRIES)) u_mon (.mclk(mclk), .rst_n(rst_n),
   .src_mode(src_mode), .cmd_start(cmd_start), .cmd_pause(cmd_pause), .cmd_stop(cmd_stop),
   .vid_locked(vid_locked), .show(show), .seq_running(seq_running),
   .seq_error(seq_error), .seq_valid(seq_valid));
`default_nettype wire

// ==== sim/pseqc_host.sv ====
// Host model: uploads entries and issues commands
`timescale 1ns/1ps
`default_nettype none
module pseqc_host
   import pseqc_pkg::*;
(
   input wire logic               mclk,
   output var logic               wr_en,
   output var pseqc_link_type     wr_link,
   output var logic [IDX_W-1:0]   wr_index,
   output var pseqc_entry_type    wr_entry,
   output var logic               wr_done,
   output var logic [IDX_W-1:0]   wr_count,
   output var logic               cmd_start,
   output var logic               cmd_pause,
   output var logic               cmd_stop
);
   // Quiet levels on every strobe and field before the first request
   task automatic idle();
      wr_en <= 1'b0;
      wr_done <= 1'b0;
      cmd_start <= 1'b0;
      cmd_pause <= 1'b0;
      cmd_stop <= 1'b0;
      wr_link <= PSEQC_LINK_USB;
      wr_index <= '0;
      wr_entry <= '0;
      wr_count <= '0;
   endtask : idle
   // One entry; released data shows the inverse, never the old value
   task automatic put(input logic [IDX_W-1:0] i, input pseqc_entry_type e,
                      input pseqc_link_type l);
      @(posedge mclk);
      wr_en <= 1'b1;
      wr_index <= i;
      wr_entry <= e;
      wr_link <= l;
      @(posedge mclk);
      wr_en <= 1'b0;
      wr_entry <= ~e;
   endtask : put
   // Upload closed before any start is sent
   task automatic fin(input logic [IDX_W-1:0] n);
      @(posedge mclk);
      wr_done <= 1'b1;
      wr_count <= n;
      @(posedge mclk);
      wr_done <= 1'b0;
   endtask : fin
   // Command pulse: 0 start, 1 pause, 2 stop
   task automatic cmd(input logic [1:0] k);
      @(posedge mclk);
      cmd_start <= (k == 2'h0);
      cmd_pause <= (k == 2'h1);
      cmd_stop <= (k == 2'h2);
      @(posedge mclk);
      {cmd_start, cmd_pause, cmd_stop} <= 3'h0;
      // Return off the edge so callers never sample where outputs launch
      @(negedge mclk);
   endtask : cmd
endmodule : pseqc_host
`default_nettype wire

// ==== sim/pseqc_ctrl_tb.sv ====
// Testbench: playback, loop, pause/stop, video and refusal scenarios
`timescale 1ns/1ps
`default_nettype none
module pseqc_ctrl_tb;
   import pseqc_pkg::*;
   logic mclk;
   logic rst_n;
   pseqc_src_type src_mode;
   logic repeat_mode;
   logic vid_vsync;
   logic vid_locked;
   logic wr_en, wr_done, cmd_start, cmd_pause, cmd_stop, seq_running, seq_error, seq_valid;
   pseqc_link_type wr_link;
   logic [IDX_W-1:0] wr_index, wr_count;
   pseqc_entry_type wr_entry;
   pseqc_show_type show;
   int n_fail = 0;
   int total_checks = 0;
   int cyc = 0;
   int lo, hi;

   initial begin
      mclk = 1'b0;
      forever #10 mclk = ~mclk;
   end
   pseqc_ctrl #(.ENTRIES(MAX_ENTRIES)) uut (.mclk(mclk), .rst_n(rst_n), .src_mode(src_mode),
      .repeat_mode(repeat_mode), .wr_en(wr_en), .wr_link(wr_link), .wr_index(wr_index),
      .wr_entry(wr_entry), .wr_done(wr_done), .wr_count(wr_count), .cmd_start(cmd_start),
      .cmd_pause(cmd_pause), .cmd_stop(cmd_stop), .vid_vsync(vid_vsync),
      .vid_locked(vid_locked), .show(show), .seq_running(seq_running),
      .seq_error(seq_error), .seq_valid(seq_valid));
   pseqc_host h (.mclk(mclk), .wr_en(wr_en), .wr_link(wr_link), .wr_index(wr_index),
      .wr_entry(wr_entry), .wr_done(wr_done), .wr_count(wr_count), .cmd_start(cmd_start),
      .cmd_pause(cmd_pause), .cmd_stop(cmd_stop));

   task automatic wrap_up();
      $display("Checks %0d, mismatches %0d", total_checks, n_fail);
      if (n_fail == 0 && total_checks > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask : wrap_up
   task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
      total_checks++;
      if (got !== exp) begin
         n_fail++;
         $display("Error %s expected %h seen %h", nm, exp, got);
      end
   endtask : chk
   // Entry of one microsecond exposure and one microsecond dark
   function automatic pseqc_entry_type ent(input logic [3:0] d, input pseqc_color_type c,
                                           input logic [8:0] im);
      return '{d, 24'h00_0001, 24'h00_0001, c, im};
   endfunction : ent
   // Wait for exposure, counting dark cycles, then check the entry shown
   task automatic up(input logic [8:0] i);
      lo = 0;
      while (show.lit !== 1'b1 && lo < 4000) begin
         @(negedge mclk);
         lo++;
      end
      chk("lit", 1, show.lit);
      chk("index", i, show.index);
   endtask : up
   task automatic dn();
      hi = 0;
      while (show.lit === 1'b1 && hi < 4000) begin
         @(negedge mclk);
         hi++;
      end
      chk("unlit", 0, show.lit);
   endtask : dn

   task automatic t_play();
      h.put(0, ent(4'h1, PSEQC_COL_RED, 9'h000), PSEQC_LINK_USB);
      h.put(1, ent(4'h8, PSEQC_COL_BLUE, 9'h18F), PSEQC_LINK_I2C);
      h.fin(1);
      @(negedge mclk);
      chk("valid", 1, seq_valid);
      h.cmd(0);
      up(0);
      chk("color", PSEQC_COL_RED, show.color);
      dn();
      chk("expose", 1, hi >= 50 && hi <= 51);
      up(1);
      chk("dark", 1, lo >= 50 && lo <= 52);
      chk("depth", 8, show.depth);
      chk("image", 9'h18F, show.image);
      repeat (300) @(negedge mclk);
      chk("once", 0, seq_running);
   endtask : t_play
   task automatic t_loop();
      @(posedge mclk) src_mode <= PSEQC_SRC_UPLOAD;
      @(posedge mclk) repeat_mode <= 1'b1;
      h.cmd(0);
      up(0);
      dn();
      up(1);
      dn();
      up(0);
      dn();
      up(1);
      h.cmd(1);
      repeat (4) @(negedge mclk);
      chk("paused", 0, seq_running);
      h.cmd(0);
      up(1);
      h.cmd(2);
      repeat (4) @(negedge mclk);
      h.cmd(0);
      up(0);
      h.cmd(2);
   endtask : t_loop
   task automatic t_video();
      @(posedge mclk) src_mode <= PSEQC_SRC_VIDEO;
      @(posedge mclk) vid_locked <= 1'b0;
      repeat (8) @(negedge mclk);
      chk("curtain", 1, show.curtain);
      @(posedge mclk) vid_locked <= 1'b1;
      repeat (8) @(negedge mclk);
      chk("curtain", 0, show.curtain);
      h.cmd(0);
      up(0);
      @(posedge mclk) vid_vsync <= 1'b1;
      repeat (4) @(posedge mclk);
      vid_vsync <= 1'b0;
      lo = 0;
      while (show.index !== 9'h001 && lo < 400) begin
         @(negedge mclk);
         lo++;
      end
      chk("advance", 1, show.index);
      h.cmd(2);
   endtask : t_video
   // Mid-run reset: clears the sticky error and the valid flag
   task automatic rst_pulse();
      @(posedge mclk) rst_n <= 1'b0;
      repeat (2) @(posedge mclk);
      rst_n <= 1'b1;
      @(negedge mclk);
      chk("error", 0, seq_error);
      chk("valid", 0, seq_valid);
   endtask : rst_pulse
   task automatic t_bad();
      @(posedge mclk) src_mode <= PSEQC_SRC_FLASH;
      h.put(0, ent(4'h1, PSEQC_COL_GREEN, 9'h190), PSEQC_LINK_USB);
      h.fin(0);
      @(negedge mclk);
      chk("valid", 0, seq_valid);
      chk("error", 1, seq_error);
      h.cmd(0);
      repeat (4) @(negedge mclk);
      chk("refused", 0, seq_running);
      // Start with nothing uploaded must itself raise the error
      rst_pulse();
      h.cmd(0);
      chk("error", 1, seq_error);
      chk("refused", 0, seq_running);
      // Bit depth above the limit
      rst_pulse();
      h.put(0, ent(4'h9, PSEQC_COL_RED, 9'h000), PSEQC_LINK_USB);
      @(negedge mclk);
      chk("error", 1, seq_error);
      // Link code that is neither of the two links
      rst_pulse();
      h.put(0, ent(4'h1, PSEQC_COL_RED, 9'h000), pseqc_link_type'(2'h3));
      @(negedge mclk);
      chk("error", 1, seq_error);
      // Zero exposure
      rst_pulse();
      h.put(0, '{4'h1, 24'h00_0000, 24'h00_0001, PSEQC_COL_RED, 9'h000},
            PSEQC_LINK_I2C);
      @(negedge mclk);
      chk("error", 1, seq_error);
   endtask : t_bad

   // Hang guard: the scenarios need about a thousand cycles
   always @(posedge mclk) begin
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         n_fail++;
         wrap_up();
      end
   end
   initial begin
      rst_n <= 1'b0;
      src_mode <= PSEQC_SRC_FLASH;
      repeat_mode <= 1'b0;
      vid_vsync <= 1'b0;
      vid_locked <= 1'b1;
      h.idle();
      repeat (10) @(posedge mclk);
      rst_n <= 1'b1;
      t_play();
      t_loop();
      t_video();
      t_bad();
      wrap_up();
   end
endmodule : pseqc_ctrl_tb
`default_nettype wire
